// ### seq_pkg.sv
// Purpose: constants for the strap and clock driven power sequencer
// Assumes: system clock of 25 MHz
// Notes: times are kept in their own unit, cycle counts derived
package seq_pkg;
   // ****************************************
   // clock and timing
   // ****************************************
   localparam int unsigned sys_clk_hz = 25000000;
   localparam int unsigned init_wait_us = 2000;
   localparam int unsigned shutdown_wait_us = 100000;
   localparam int unsigned ramp_down_us = 10000;
   localparam int unsigned clock_lost_ns = 2000;
   localparam int unsigned init_cycles = (init_wait_us * (sys_clk_hz / 1000000));
   localparam int unsigned shutdown_cycles = (shutdown_wait_us * (sys_clk_hz / 1000000));
   localparam int unsigned ramp_cycles = (ramp_down_us * (sys_clk_hz / 1000000));
   localparam int unsigned clock_lost_cycles = (clock_lost_ns + 39) / 40;
   // ****************************************
   // widths and reset values
   // ****************************************
   localparam int cnt_w = 24;
   localparam int strap_w = 6;
   localparam logic [5:0] strap_rst = 6'h00;
   typedef enum logic [2:0] {st_init, st_sleep, st_active, st_ramp, st_blocks_off} seq_state_t;
endpackage : seq_pkg

// ### strap_clock_power_sequencer.sv
// Purpose: power-up, sleep, wake and shutdown sequencing of a pin-configured audio converter
// Assumes: i_rst_n stands for supply power-up; straps and clocks are asynchronous pins
// Notes: format strap is caught once after reset release; mode straps at each wake
//
// Contract
// [R1] serial format comes from the format strap level captured at power-up
// [R2] after power-up the device initialises for 2 ms before anything else
// [R3] after initialisation and without serial clocks the device stays asleep
// [R4] host sets and holds the six config straps before starting clocks
// [R5] device wakes when bit clock and frame clock both start toggling
// [R6] stopping clocks starts shutdown; host waits 100 ms before changing straps
// [R7] a format change needs a strap change plus a full power cycle
// [R8] power-down ramps volume, turns blocks off, then enters low power; 10 ms
// [R9] channels power up while clocks run, power down when they stop
// [R10] clock stop or error latches the interrupt until power cycle; here only a clock stop while active sets it
// [R11] config straps sampled at wake, changes ignored while active
`timescale 1ns/1ps
`default_nettype none
module strap_clock_power_sequencer
   import seq_pkg::*;
#(
   parameter int unsigned init_cnt = init_cycles,
   parameter int unsigned ramp_cnt = ramp_cycles,
   parameter int unsigned shutdown_cnt = shutdown_cycles
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // audio serial port clocks
   input wire logic i_bit_clock,
   input wire logic i_frame_sync_clock,
   // straps
   input wire logic i_interface_format_strap,
   input wire logic [strap_w-1:0] i_config_straps,
   // status
   output logic o_format,
   output logic [strap_w-1:0] o_config,
   output logic o_sleep,
   output logic o_channels_on,
   output logic o_volume_ramp,
   output logic o_blocks_on,
   output logic o_straps_locked,
   output logic o_general_output_pin
);
   // ****************************************
   // synchronisers
   // ****************************************
   logic [1:0] bclk_s;
   logic [1:0] fs_s;
   logic [1:0] fmt_s;
   logic [2*strap_w-1:0] cfg_s;
   logic bclk_d;
   logic fs_d;
   always_ff @(posedge i_clk_sys) begin
      bclk_s <= {bclk_s[0], i_bit_clock};
      fs_s <= {fs_s[0], i_frame_sync_clock};
      fmt_s <= {fmt_s[0], i_interface_format_strap};
      cfg_s <= {cfg_s[strap_w-1:0], i_config_straps};
      bclk_d <= bclk_s[1];
      fs_d <= fs_s[1];
   end
   wire bclk_edge = bclk_s[1] ^ bclk_d;
   wire fs_edge = fs_s[1] ^ fs_d;
   wire [strap_w-1:0] cfg_sync = cfg_s[2*strap_w-1:strap_w];

   // ****************************************
   // clock presence watch
   // ****************************************
   // frame clock is far slower than bit clock, so its watchdog is the long one
   localparam int unsigned fs_lost_cycles = 4096;
   logic [12:0] bclk_idle;
   logic [12:0] fs_idle;
   logic bclk_seen;
   logic fs_seen;
   wire bclk_lost = (bclk_idle >= 13'(clock_lost_cycles * 64));
   wire fs_lost = (fs_idle >= 13'(fs_lost_cycles));
   wire clocks_ok = bclk_seen & fs_seen & ~bclk_lost & ~fs_lost;
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         bclk_idle <= 13'h0000;
         fs_idle <= 13'h0000;
         bclk_seen <= 1'b0;
         fs_seen <= 1'b0;
      end else begin
         bclk_idle <= bclk_edge ? 13'h0000 : (bclk_lost ? bclk_idle : bclk_idle + 13'h0001);
         fs_idle <= fs_edge ? 13'h0000 : (fs_lost ? fs_idle : fs_idle + 13'h0001);
         bclk_seen <= bclk_edge | (bclk_seen & ~bclk_lost);
         fs_seen <= fs_edge | (fs_seen & ~fs_lost);
      end
   end

   // ****************************************
   // sequencer
   // ****************************************
   seq_state_t state;
   seq_state_t next_state;
   logic [cnt_w-1:0] cnt;
   logic fmt_taken;
   wire cnt_done_init = (cnt >= cnt_w'(init_cnt - 1));
   wire cnt_done_ramp = (cnt >= cnt_w'(ramp_cnt / 2 - 1));
   wire cnt_done_off = (cnt >= cnt_w'(ramp_cnt - ramp_cnt / 2 - 1));
   always_comb begin
      next_state = state;
      unique case (state)
         st_init: if (cnt_done_init) next_state = st_sleep; // R2
         st_sleep: if (clocks_ok) next_state = st_active; // R3 R5
         st_active: if (!clocks_ok) next_state = st_ramp; // R6 R9
         st_ramp: if (cnt_done_ramp) next_state = st_blocks_off; // R8
         st_blocks_off: if (cnt_done_off) next_state = st_sleep; // R8
      endcase
   end
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         state <= st_init;
         cnt <= '0;
      end else begin
         state <= next_state;
         cnt <= (next_state != state) ? '0 : cnt + 1'b1;
      end
   end

   // ****************************************
   // straps and outputs
   // ****************************************
   // format is taken once after release; only a reset (power cycle) reloads it
   wire take_cfg = (state == st_sleep) && (next_state == st_active);
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         fmt_taken <= 1'b0;
         o_format <= 1'b0;
         o_config <= strap_rst;
         o_general_output_pin <= 1'b0;
         o_sleep <= 1'b0;
         o_channels_on <= 1'b0;
         o_volume_ramp <= 1'b0;
         o_blocks_on <= 1'b0;
         o_straps_locked <= 1'b0;
      end else begin
         if (!fmt_taken && state == st_init) begin
            fmt_taken <= 1'b1;
            o_format <= fmt_s[1]; // R1 R7
         end
         if (take_cfg) o_config <= cfg_sync; // R11 R4
         if (state == st_active && !clocks_ok) o_general_output_pin <= 1'b1; // R10
         o_sleep <= (next_state == st_sleep); // R3
         o_channels_on <= (next_state == st_active); // R9
         o_volume_ramp <= (next_state == st_ramp); // R8
         o_blocks_on <= (next_state == st_active) || (next_state == st_ramp);
         o_straps_locked <= (next_state == st_active); // R11
      end
   end
endmodule : strap_clock_power_sequencer
`default_nettype wire

// ### sequencer_checker_assertions.sv
// Purpose: port checks for the power sequencer
// Assumes: one clock domain; Notes: ramp figures follow ramp_cnt
`timescale 1ns/1ps
`default_nettype none
module sequencer_checker
   import seq_pkg::*;
#(parameter int unsigned ramp_cnt = 40) (
   input wire logic i_clk_sys, i_rst_n, o_format, o_sleep, o_channels_on, o_volume_ramp,
   input wire logic o_blocks_on, o_straps_locked, o_general_output_pin,
   input wire logic [strap_w-1:0] o_config
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   localparam int half_m1 = ramp_cnt / 2 - 1, rest_m1 = ramp_cnt - ramp_cnt / 2 - 1;
   chk_sleep_quiet: assert property (o_sleep |-> !o_channels_on && !o_blocks_on) else $error("awake");
   chk_active_lock: assert property (o_channels_on |-> o_blocks_on && o_straps_locked) else $error("lock");
   chk_irq_latch: assert property (o_general_output_pin |=> o_general_output_pin) else $error("irq");
   chk_stop_ramp: assert property ($fell(o_channels_on) |-> o_volume_ramp && o_general_output_pin)
      else $error("no ramp");
   // the capture edge itself is the first edge after release, so look only from two edges on
   chk_format_hold: assert property ($past(i_rst_n, 2) |-> $stable(o_format)) else $error("format");
   chk_config_hold: assert property (o_straps_locked && $past(o_straps_locked) |-> $stable(o_config))
      else $error("config");
   chk_ramp_len: assert property ($rose(o_volume_ramp) |-> ##half_m1 o_volume_ramp ##1 !o_volume_ramp && !o_blocks_on)
      else $error("ramp");
   chk_off_len: assert property ($fell(o_blocks_on) |-> ##rest_m1 !o_sleep ##1 o_sleep) else $error("off");
endmodule : sequencer_checker
`default_nettype wire
bind strap_clock_power_sequencer sequencer_checker #(.ramp_cnt(ramp_cnt)) chk (.*);

// ### audio_host.sv
// Purpose: host model driving the bit and frame clocks
// Assumes: clocks stand still when stopped; Notes: off phase from the system clock
`timescale 1ns/1ps
`default_nettype none
module audio_host (input wire logic i_run, output logic o_bit_clock, output logic o_frame_sync_clock);
   int n = 0;
   initial begin
      o_bit_clock = 1'h0;
      o_frame_sync_clock = 1'h0;
      #7;
      forever begin
         #160;
         o_bit_clock = i_run & ~o_bit_clock;
         n = n + i_run;
         // frame edge every 32 bit periods, well inside the loss limit
         if (i_run && n % 64 == 0) o_frame_sync_clock = ~o_frame_sync_clock;
      end
   end
endmodule : audio_host
`default_nettype wire

// ### strap_clock_power_sequencer_test.sv
// Purpose: self-checking bench for the sequencer
// Assumes: short init and ramp counts; Notes: host wait also shortened
`timescale 1ns/1ps
`default_nettype none
module strap_clock_power_sequencer_test;
   import seq_pkg::*;
   logic i_clk_sys, i_rst_n, run, i_interface_format_strap, i_bit_clock, i_frame_sync_clock, o_format, o_sleep;
   logic o_channels_on, o_volume_ramp, o_blocks_on, o_straps_locked, o_general_output_pin;
   logic [strap_w-1:0] i_config_straps, o_config;
   logic [5:0] rows [3] = '{6'h00, 6'h3f, 6'h25};
   int fail_count = 0, tests_run = 0, cyc = 0, k;
   strap_clock_power_sequencer #(.init_cnt(50), .ramp_cnt(40), .shutdown_cnt(100)) dut (.*);
   audio_host host (.i_run(run), .o_bit_clock(i_bit_clock), .o_frame_sync_clock(i_frame_sync_clock));
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run
   // every wait passes through here, so the ceiling bounds any hang
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
      cyc += n;
      if (cyc > 40000) begin
         fail_count++;
         complete_run();
      end
   endtask : tick
   initial begin
      i_clk_sys = 1'h0;
      forever #20 i_clk_sys = ~i_clk_sys;
   end
   initial begin
      i_rst_n = 1'h0;
      run = 1'h0;
      i_interface_format_strap = 1'h1;
      i_config_straps = 6'h00;
      tick(16);
      check({o_format, o_sleep, o_channels_on, o_general_output_pin}, 12'h0);
      i_rst_n = 1'h1;
      tick(2);
      i_interface_format_strap = 1'h0;
      tick(100);
      check({o_format, o_sleep, o_channels_on}, 12'h6);
      foreach (rows[i]) begin
         i_config_straps = rows[i];
         tick(2);
         run = 1'h1;
         for (k = 0; k < 2000 && o_channels_on !== 1'h1; k++) tick(1);
         check({o_sleep, o_blocks_on, o_straps_locked, 3'h0, o_config}, {6'h18, rows[i]});
         i_config_straps = ~rows[i];
         tick(10);
         check(o_config, rows[i]);
         run = 1'h0;
         for (k = 0; k < 5000 && o_channels_on !== 1'h0; k++) tick(1);
         check({o_volume_ramp, o_blocks_on, o_general_output_pin}, 12'h7);
         for (k = 0; k < 100 && o_sleep !== 1'h1; k++) tick(1);
         check({o_sleep, o_volume_ramp, o_blocks_on, o_general_output_pin}, 12'h9);
         tick(100);
      end
      i_rst_n = 1'h0;
      tick(3);
      check({o_format, o_general_output_pin, o_config}, 12'h0);
      i_rst_n = 1'h1;
      tick(100);
      check({o_format, o_sleep}, 12'h1);
      complete_run();
   end
endmodule : strap_clock_power_sequencer_test
`default_nettype wire
